// ==== rtl/gcs_command_ctrl.v ====
// General command interpreter with sync, termination and level settings
// Overview of operation
// - Help with name gives that command's help
// - Identity reports ten fields in fixed order
// - Echo on: reply carries command name first
// - Print lists all parameters with values
// - Print ALL adds identity
// - Sync none: no pulses out or in
// - Master drives pulses on differential line
// - Differential follower aligns to incoming pulses
// - Single-ended follower aligns to generator pulses
// - Line direction follows the sync mode
// - Single-ended input also serves as trigger
// - Termination resistor switched on or off
// - Level select applies to single-ended input
`timescale 1ns/1ps
`include "gcs_regs.vh"
module gcs_command_ctrl #(
  parameter [15:0] SYNC_PERIOD = `GCS_SYNC_PERIOD
) (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    rst,
  // Parsed command from the ASCII front end
  input  wire                    cmdValid,
  output wire                    cmdReady,
  input  wire [`GCS_CMD_W-1:0]   cmdCode,
  input  wire [`GCS_ARG_W-1:0]   cmdArg,
  input  wire [7:0]              cmdNameId,
  // Reply item stream to the text formatter
  output reg                     replyValid,
  input  wire                    replyReady,
  output reg  [`GCS_ITEM_W-1:0]  replyItem,
  output reg  [7:0]              replyTag,
  output reg                     replyLast,
  // Settings visible to the rest of the controller
  output reg                     echoOn,
  output reg  [1:0]              syncMode,
  output reg                     termEnable,
  output reg                     seLevelHtl,
  // Sync pins
  input  wire                    diffLineIn,
  output wire                    diffLineOut,
  output wire                    diffLineOe,
  input  wire                    seTimingIn,
  // Timing results
  output wire                    syncPulse,
  output wire                    seTrigLevel
);
  // Reply sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_NAME = 3'h1;
  localparam [2:0] ST_BODY = 3'h2;
  localparam [2:0] ST_ID   = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;

  // Captured command and identity walk
  reg [2:0]             state_q;
  reg [`GCS_CMD_W-1:0]  cmd_q;
  reg [`GCS_ARG_W-1:0]  arg_q;
  reg [7:0]             nameId_q;
  reg                   err_q;
  reg [3:0]             idIdx_q;

  // Legal arguments per command; anything else is refused
  function argOk;
    input [`GCS_CMD_W-1:0] c;
    input [`GCS_ARG_W-1:0] a;
    begin
      case (c)
        `GCS_CMD_HELP:  argOk = (a == `GCS_ARG_NONE) || (a == `GCS_ARG_NAME);
        `GCS_CMD_IDENT: argOk = (a == `GCS_ARG_NONE);
        `GCS_CMD_ECHO,
        `GCS_CMD_TERM:  argOk = (a == `GCS_ARG_ON) || (a == `GCS_ARG_OFF);
        `GCS_CMD_PRINT: argOk = (a == `GCS_ARG_NONE) || (a == `GCS_ARG_ALL);
        `GCS_CMD_SYNC:  argOk = (a >= `GCS_ARG_SYNCNONE) && (a <= `GCS_ARG_FOLSE);
        `GCS_CMD_LEVEL: argOk = (a == `GCS_ARG_TTL) || (a == `GCS_ARG_HTL);
        default:        argOk = 1'b0;
      endcase
    end
  endfunction

  // Index of the final identity field
  function lastField;
    input [3:0] idx;
    begin
      lastField = (idx == `GCS_ID_FIELDS - 4'h1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // One command at a time; next is taken only after the reply ends
  assign cmdReady = (state_q == ST_IDLE);

  always @(posedge sys_clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      cmd_q      <= {`GCS_CMD_W{1'b0}};
      arg_q      <= {`GCS_ARG_W{1'b0}};
      nameId_q   <= 8'h00;
      err_q      <= 1'b0;
      idIdx_q    <= 4'h0;
      replyValid <= 1'b0;
      replyItem  <= `GCS_ITEM_NAME;
      replyTag   <= 8'h00;
      replyLast  <= 1'b0;
      echoOn     <= `GCS_RST_ECHO;
      syncMode   <= `GCS_RST_SYNC;
      termEnable <= `GCS_RST_TERM;
      seLevelHtl <= `GCS_RST_LEVEL;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmdValid) begin
            cmd_q    <= cmdCode;
            arg_q    <= cmdArg;
            nameId_q <= cmdNameId;
            err_q    <= ~argOk(cmdCode, cmdArg);
            if (argOk(cmdCode, cmdArg)) begin
              // Settings change only on a clean command
              case (cmdCode)
                `GCS_CMD_ECHO:  echoOn     <= (cmdArg == `GCS_ARG_ON);
                `GCS_CMD_TERM:  termEnable <= (cmdArg == `GCS_ARG_ON);
                `GCS_CMD_LEVEL: seLevelHtl <= (cmdArg == `GCS_ARG_HTL);
                `GCS_CMD_SYNC:  syncMode   <= cmdArg[1:0];
                default: ;
              endcase
            end
            // Name goes out under the echo setting in force before this command
            replyTag   <= {4'h0, cmdCode};
            replyLast  <= 1'b0;
            replyItem  <= `GCS_ITEM_NAME;
            if (echoOn) begin
              replyValid <= 1'b1;
              state_q    <= ST_NAME;
            end else begin
              // Nothing out this cycle; the body follows one cycle later
              replyValid <= 1'b0;
              state_q    <= ST_BODY;
            end
          end
        end
        ST_NAME: begin
          if (replyReady) begin
            replyValid <= 1'b0;
            state_q    <= ST_BODY;
          end
        end
        ST_BODY: begin
          replyValid <= 1'b1;
          replyLast  <= 1'b1;
          replyTag   <= 8'h00;
          state_q    <= ST_DONE;
          if (err_q) begin
            replyItem <= `GCS_ITEM_ERROR;
          end else begin
            case (cmd_q)
              `GCS_CMD_HELP: begin
                replyItem <= (arg_q == `GCS_ARG_NAME) ? `GCS_ITEM_HELPCMD
                                                      : `GCS_ITEM_HELPGEN;
                replyTag  <= (arg_q == `GCS_ARG_NAME) ? nameId_q : 8'h00;
              end
              `GCS_CMD_IDENT: begin
                replyItem <= `GCS_ITEM_IDBASE;
                replyLast <= 1'b0;
                idIdx_q   <= 4'h1;
                state_q   <= ST_ID;
              end
              `GCS_CMD_PRINT: begin
                replyItem <= `GCS_ITEM_PARAMS;
                replyTag  <= {7'h00, arg_q == `GCS_ARG_ALL};
                replyLast <= (arg_q != `GCS_ARG_ALL);
                idIdx_q   <= 4'h0;
                // ALL appends the identity fields after the parameter list
                state_q   <= (arg_q == `GCS_ARG_ALL) ? ST_ID : ST_DONE;
              end
              default: begin
                replyItem <= `GCS_ITEM_ANSWER;
                replyTag  <= {4'h0, arg_q};
              end
            endcase
          end
        end
        ST_ID: begin
          if (replyReady) begin
            replyItem <= `GCS_ITEM_IDBASE + idIdx_q;
            replyTag  <= {4'h0, idIdx_q};
            // For identity, field 0 already went out from the body state; print ALL starts here at field 0
            replyLast <= lastField(idIdx_q);
            if (lastField(idIdx_q)) begin
              state_q <= ST_DONE;
            end
            idIdx_q <= idIdx_q + 4'h1;
          end
        end
        ST_DONE: begin
          if (replyReady) begin
            replyValid <= 1'b0;
            replyLast  <= 1'b0;
            state_q    <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  gcs_sync_unit #(
    .PERIOD(SYNC_PERIOD)
  ) i_gcs_sync_unit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .syncMode   (syncMode),
    .diffLineIn (diffLineIn),
    .diffLineOut(diffLineOut),
    .diffLineOe (diffLineOe),
    .seTimingIn (seTimingIn),
    .syncPulse  (syncPulse),
    .seTrigLevel(seTrigLevel)
  );
endmodule

// ==== rtl/gcs_regs.vh ====
// Constants of the general command and sync control block
`ifndef GCS_REGS_VH
`define GCS_REGS_VH
// Command codes
`define GCS_CMD_W        4
`define GCS_CMD_HELP     4'h1
`define GCS_CMD_IDENT    4'h2
`define GCS_CMD_ECHO     4'h3
`define GCS_CMD_PRINT    4'h4
`define GCS_CMD_SYNC     4'h5
`define GCS_CMD_TERM     4'h6
`define GCS_CMD_LEVEL    4'h7
// Argument codes
`define GCS_ARG_W        4
`define GCS_ARG_NONE     4'h0
`define GCS_ARG_OFF      4'h1
`define GCS_ARG_ON       4'h2
`define GCS_ARG_ALL      4'h3
`define GCS_ARG_SYNCNONE 4'h4
`define GCS_ARG_MASTER   4'h5
`define GCS_ARG_FOLDIFF  4'h6
`define GCS_ARG_FOLSE    4'h7
`define GCS_ARG_TTL      4'h8
`define GCS_ARG_HTL      4'h9
`define GCS_ARG_NAME     4'ha
// Sync modes
`define GCS_SYNC_NONE    2'h0
`define GCS_SYNC_MASTER  2'h1
`define GCS_SYNC_FOLDIFF 2'h2
`define GCS_SYNC_FOLSE   2'h3
// Reply item codes
`define GCS_ITEM_W       4
`define GCS_ITEM_NAME    4'h0
`define GCS_ITEM_ANSWER  4'h1
`define GCS_ITEM_ERROR   4'h2
`define GCS_ITEM_HELPGEN 4'h3
`define GCS_ITEM_HELPCMD 4'h4
`define GCS_ITEM_IDBASE  4'h5
`define GCS_ITEM_PARAMS  4'hf
`define GCS_ID_FIELDS    4'ha
// Reset values
`define GCS_RST_ECHO     1'b1
`define GCS_RST_SYNC     2'h0
`define GCS_RST_TERM     1'b0
`define GCS_RST_LEVEL    1'b0
// Master pulse period in sys_clk cycles
`define GCS_SYNC_PERIOD  16'h0064
`endif

// ==== rtl/gcs_sync_unit.v ====
// Sync line direction, master pulse generator and follower pulse alignment
`timescale 1ns/1ps
`include "gcs_regs.vh"
module gcs_sync_unit #(
  parameter [15:0] PERIOD = `GCS_SYNC_PERIOD
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Mode
  input  wire [1:0] syncMode,
  // Pins
  input  wire       diffLineIn,
  output wire       diffLineOut,
  output wire       diffLineOe,
  input  wire       seTimingIn,
  // Results
  output reg        syncPulse,
  output reg        seTrigLevel
);
  reg [15:0] cnt_q;
  reg [1:0]  diffSync_q;
  reg [1:0]  seSync_q;
  reg        diffLast_q;
  reg        seLast_q;
  reg        pulseOut_q;
  wire       isMaster = (syncMode == `GCS_SYNC_MASTER);

  ////////////////////////////////////////////////////////////////////
  // Line drives only in master mode, never as follower
  assign diffLineOe  = isMaster;
  // Gated so a tick launched on the edge that leaves master never shows
  assign diffLineOut = pulseOut_q & isMaster;

  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_q       <= 16'h0000;
      diffSync_q  <= 2'h0;
      seSync_q    <= 2'h0;
      diffLast_q  <= 1'b0;
      seLast_q    <= 1'b0;
      pulseOut_q  <= 1'b0;
      syncPulse   <= 1'b0;
      seTrigLevel <= 1'b0;
    end else begin
      diffSync_q  <= {diffSync_q[0], diffLineIn};
      seSync_q    <= {seSync_q[0], seTimingIn};
      diffLast_q  <= diffSync_q[1];
      seLast_q    <= seSync_q[1];
      seTrigLevel <= seSync_q[1];
      pulseOut_q  <= 1'b0;
      syncPulse   <= 1'b0;
      if (isMaster) begin
        if (cnt_q == PERIOD - 16'h0001) begin
          cnt_q      <= 16'h0000;
          pulseOut_q <= 1'b1;
          syncPulse  <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end else begin
        cnt_q <= 16'h0000;
        case (syncMode)
          `GCS_SYNC_FOLDIFF: syncPulse <= diffSync_q[1] & ~diffLast_q;
          `GCS_SYNC_FOLSE:   syncPulse <= seSync_q[1] & ~seLast_q;
          default:           syncPulse <= 1'b0;
        endcase
      end
    end
  end
endmodule

// ==== test/gcs_command_ctrl_monitor.sv ====
// Checker of the command and sync control ports
`timescale 1ns/1ps
`include "gcs_regs.vh"
module gcs_command_ctrl_monitor #(
  parameter [15:0] SYNC_PERIOD = `GCS_SYNC_PERIOD
) (
  // Clock and reset
  input wire       sys_clk,
  input wire       rst,
  // Command and reply
  input wire       cmdValid,
  input wire       cmdReady,
  input wire [3:0] cmdCode,
  input wire [3:0] cmdArg,
  input wire       replyValid,
  input wire [3:0] replyItem,
  input wire [7:0] replyTag,
  // Settings and pins
  input wire       echoOn,
  input wire [1:0] syncMode,
  input wire       termEnable,
  input wire       seLevelHtl,
  input wire       diffLineOut,
  input wire       diffLineOe,
  input wire       syncPulse
);
  wire take = cmdValid && cmdReady;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_OE: assert property (diffLineOe == (syncMode == `GCS_SYNC_MASTER))
    else $error("line direction wrong");
  AST_QUIET: assert property (syncMode != `GCS_SYNC_MASTER |-> !diffLineOut)
    else $error("line driven outside master");
  AST_NONE: assert property (syncMode == 2'h0 && $past(syncMode) == 2'h0
    |-> !syncPulse) else $error("pulse in mode none");
  // Gap of seven holds only for the shortened period of eight
  AST_PERIOD: assert property (diffLineOut && SYNC_PERIOD == 16'h0008 |=>
    !diffLineOut [*7] ##1 (diffLineOut || syncMode != `GCS_SYNC_MASTER))
    else $error("master period wrong");
  AST_ECHO: assert property (take && echoOn |=> replyValid &&
    replyItem == `GCS_ITEM_NAME && replyTag == {4'h0, $past(cmdCode)}) else $error("no name");
  AST_BARE: assert property (take && !echoOn |=> !replyValid ##1
    (replyValid && replyItem != `GCS_ITEM_NAME)) else $error("bare reply wrong");
  AST_KEEP: assert property (take && cmdCode == `GCS_CMD_SYNC && cmdArg < 4'h4
    |=> $stable(syncMode)) else $error("bad arg changed mode");
  AST_SYNC: assert property (take && cmdCode == `GCS_CMD_SYNC && cmdArg >= 4'h4 &&
    cmdArg <= 4'h7 |=> {2'h0, syncMode} == $past(cmdArg) - 4'h4)
    else $error("sync mode not taken");
  AST_TERM: assert property (take && cmdCode == `GCS_CMD_TERM &&
    (cmdArg == 4'h1 || cmdArg == 4'h2) |=> termEnable == ($past(cmdArg) == 4'h2))
    else $error("termination wrong");
  AST_LEVEL: assert property (take && cmdCode == `GCS_CMD_LEVEL &&
    (cmdArg == 4'h8 || cmdArg == 4'h9) |=> seLevelHtl == ($past(cmdArg) == 4'h9))
    else $error("level wrong");
endmodule
bind gcs_command_ctrl gcs_command_ctrl_monitor #(.SYNC_PERIOD(SYNC_PERIOD)) i_mon (.sys_clk,
  .rst, .cmdValid, .cmdReady, .cmdCode, .cmdArg, .replyValid, .replyItem, .replyTag, .echoOn,
  .syncMode, .termEnable, .seLevelHtl, .diffLineOut, .diffLineOe, .syncPulse);

// ==== test/gcs_peer_model.sv ====
// Peer controller and pulse generator on the sync pins
`timescale 1ns/1ps
module gcs_peer_model (
  // Clock
  input  wire sys_clk,
  // Device side of the line
  input  wire diffLineOut,
  input  wire diffLineOe,
  // Pins toward the device
  output wire diffLineIn,
  output reg  seTimingIn
);
  reg [4:0] cnt_q       = 5'h00;
  reg       peerPulse_q = 1'b0;
  initial seTimingIn = 1'b0;
  // Peer is master only while the device is not, so one end drives
  assign diffLineIn = diffLineOe ? diffLineOut : peerPulse_q;
  always @(posedge sys_clk) begin
    cnt_q       <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
    peerPulse_q <= (cnt_q == 5'h05) || (cnt_q == 5'h0f);
    if (cnt_q == 5'h09) begin
      seTimingIn <= ~seTimingIn;
    end
  end
endmodule

// ==== test/general_command_and_sync_control_tb.sv ====
// Testbench of the general command and sync control block
`timescale 1ns/1ps
`include "gcs_regs.vh"
module general_command_and_sync_control_tb;
  reg        sys_clk = 1'b0;
  reg        rst = 1'b1;
  reg        cmdValid = 1'b0;
  reg        replyReady = 1'b0;
  reg  [3:0] cmdCode = 4'h0;
  reg  [3:0] cmdArg = 4'h0;
  reg  [7:0] cmdNameId = 8'h00;
  wire       cmdReady, replyValid, replyLast, echoOn, termEnable, seLevelHtl;
  wire       diffLineIn, diffLineOut, diffLineOe, seTimingIn, syncPulse, seTrigLevel;
  wire [3:0] replyItem;
  wire [7:0] replyTag;
  wire [1:0] syncMode;
  integer    num_errors = 0;
  integer    check_count = 0;
  integer    i, j, n, p, q;
  always #25 sys_clk = ~sys_clk;
  gcs_command_ctrl #(.SYNC_PERIOD(16'h0008)) i_gcs_command_ctrl (.sys_clk, .rst, .cmdValid,
    .cmdReady, .cmdCode, .cmdArg, .cmdNameId, .replyValid, .replyReady, .replyItem, .replyTag,
    .replyLast, .echoOn, .syncMode, .termEnable, .seLevelHtl, .diffLineIn, .diffLineOut,
    .diffLineOe, .seTimingIn, .syncPulse, .seTrigLevel);
  gcs_peer_model i_gcs_peer_model (.sys_clk, .diffLineOut, .diffLineOe, .diffLineIn,
    .seTimingIn);
  task check(input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  // Bounded wait step; a hang ends the run
  task tick;
    begin
      @(negedge sys_clk);
      n = n + 1;
      if (n > 60) begin
        num_errors = num_errors + 1;
        end_of_test;
      end
    end
  endtask
  task send(input [3:0] c, input [3:0] a);
    begin
      n = 0;
      while (cmdReady !== 1'b1) tick;
      cmdCode = c;
      cmdArg = a;
      cmdValid = 1'b1;
      @(negedge sys_clk);
      cmdValid = 1'b0;
      check(cmdReady, 8'h00);
    end
  endtask
  // Tag 8'hff means the tag is not judged; ready stays up after a non-last item but drops while valid is low
  task item(input [3:0] it, input [7:0] tg, input lst);
    begin
      n = 0;
      while (replyValid !== 1'b1) begin
        replyReady = 1'b0;
        tick;
      end
      check(replyItem, it);
      if (tg !== 8'hff) check(replyTag, tg);
      check(replyLast, lst);
      replyReady = 1'b1;
      @(negedge sys_clk);
      if (lst) replyReady = 1'b0;
    end
  endtask
  task idList;
    for (i = 0; i < 10; i = i + 1) item(4'h5 + i, i, i == 9);
  endtask
  task t_basic;
    begin
      check(diffLineOe, 8'h00);
      check({echoOn, termEnable, seLevelHtl, syncMode}, 8'h10);
      cmdNameId = 8'h3c;
      send(`GCS_CMD_HELP, `GCS_ARG_NONE);
      item(`GCS_ITEM_NAME, 8'h01, 1'b0);
      item(`GCS_ITEM_HELPGEN, 8'hff, 1'b1);
      send(`GCS_CMD_HELP, `GCS_ARG_NAME);
      item(`GCS_ITEM_NAME, 8'h01, 1'b0);
      item(`GCS_ITEM_HELPCMD, 8'h3c, 1'b1);
      send(`GCS_CMD_IDENT, `GCS_ARG_NONE);
      item(`GCS_ITEM_NAME, 8'h02, 1'b0);
      idList;
      $display("test basic done");
    end
  endtask
  task t_echo;
    begin
      send(`GCS_CMD_ECHO, `GCS_ARG_OFF);
      item(`GCS_ITEM_NAME, 8'h03, 1'b0);
      item(`GCS_ITEM_ANSWER, 8'h01, 1'b1);
      send(`GCS_CMD_PRINT, `GCS_ARG_NONE);
      item(`GCS_ITEM_PARAMS, 8'h00, 1'b1);
      send(`GCS_CMD_PRINT, `GCS_ARG_ALL);
      item(`GCS_ITEM_PARAMS, 8'h01, 1'b0);
      idList;
      send(`GCS_CMD_ECHO, `GCS_ARG_ON);
      item(`GCS_ITEM_ANSWER, 8'h02, 1'b1);
      check(echoOn, 8'h01);
      $display("test echo done");
    end
  endtask
  task t_sync;
    for (j = 4; j < 8; j = j + 1) begin
      send(`GCS_CMD_SYNC, j);
      item(`GCS_ITEM_NAME, 8'h05, 1'b0);
      item(`GCS_ITEM_ANSWER, j, 1'b1);
      check(syncMode, j - 4);
      check(diffLineOe, j == 5);
      p = 0;
      q = 0;
      repeat (40) begin
        @(negedge sys_clk);
        p = p + syncPulse;
        q = q + diffLineOut;
      end
      check(p, j == 4 ? 0 : j == 5 ? 5 : j == 6 ? 4 : 1);
      check(q, j == 5 ? 5 : 0);
      $display("test sync mode %0d done", j - 4);
    end
  endtask
  task t_misc;
    begin
      send(`GCS_CMD_SYNC, `GCS_ARG_ON);
      item(`GCS_ITEM_NAME, 8'h05, 1'b0);
      item(`GCS_ITEM_ERROR, 8'hff, 1'b1);
      check(syncMode, 8'h03);
      send(4'h9, `GCS_ARG_NONE);
      item(`GCS_ITEM_NAME, 8'h09, 1'b0);
      item(`GCS_ITEM_ERROR, 8'hff, 1'b1);
      send(`GCS_CMD_TERM, `GCS_ARG_ON);
      item(`GCS_ITEM_NAME, 8'h06, 1'b0);
      item(`GCS_ITEM_ANSWER, 8'h02, 1'b1);
      send(`GCS_CMD_LEVEL, `GCS_ARG_HTL);
      item(`GCS_ITEM_NAME, 8'h07, 1'b0);
      item(`GCS_ITEM_ANSWER, 8'h09, 1'b1);
      check({termEnable, seLevelHtl}, 8'h03);
      send(`GCS_CMD_TERM, `GCS_ARG_OFF);
      item(`GCS_ITEM_NAME, 8'h06, 1'b0);
      item(`GCS_ITEM_ANSWER, 8'h01, 1'b1);
      send(`GCS_CMD_LEVEL, `GCS_ARG_TTL);
      item(`GCS_ITEM_NAME, 8'h07, 1'b0);
      item(`GCS_ITEM_ANSWER, 8'h08, 1'b1);
      check({termEnable, seLevelHtl}, 8'h00);
      n = 0;
      p = seTimingIn;
      while (seTimingIn === p) tick;
      repeat (5) @(negedge sys_clk);
      check(seTrigLevel, seTimingIn);
      $display("test misc done");
    end
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_basic;
    t_echo;
    t_sync;
    t_misc;
    end_of_test;
  end
endmodule
